// >>> dv/rsc_cause_model.sv
/*
 * Far-side model: power monitors, clear pin, watchdog and core fault logic.
 * Assumes the bench calls raise() hierarchically; lines idle low.
 */
`timescale 1ns/100ps

module rsc_cause_model (
    input wire logic mclk_i,
    output logic [6:0] cause_o
);
    initial cause_o = 7'h00;

    // level held for cyc edges, so slow monitors and one-cycle core pulses both fit
    task automatic raise(input int idx, input int cyc);
        @(posedge mclk_i);
        cause_o[idx] <= 1'b1;
        repeat (cyc) @(posedge mclk_i);
        cause_o[idx] <= 1'b0;
    endtask
endmodule

// >>> dv/rsc_reset_combiner_properties.sv
/*
 * Port-level checker of the reset source combiner.
 * Assumes it is bound onto rsc_reset_combiner and sees only its ports.
 */
`timescale 1ns/100ps

module rsc_reset_combiner_properties
    import rsc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic power_on_reset_i,
    input wire logic brown_out_reset_i,
    input wire logic external_clear_pin_reset_i,
    input wire logic instruction_reset_i,
    input wire logic watchdog_timeout_reset_i,
    input wire logic trap_conflict_reset_i,
    input wire logic illegal_op_uninit_reg_reset_i,
    input wire logic master_system_reset_o,
    input wire logic cold_reset_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [RSC_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    wire logic [2:0] sync_c = {instruction_reset_i, trap_conflict_reset_i,
        illegal_op_uninit_reg_reset_i};
    wire logic [3:0] async_c = {power_on_reset_i, brown_out_reset_i,
        external_clear_pin_reset_i, watchdog_timeout_reset_i};
    wire logic acc = psel_i && penable_i && ce_i;
    wire logic mapped = paddr_i inside {RSC_OFF_CAUSE, RSC_OFF_IRQ_STAT,
        RSC_OFF_IRQ_MASK, RSC_OFF_LIVE, RSC_OFF_HOLD, RSC_OFF_COUNT};

    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_sync_cause_asserts: assert property
        ((ce_i && |sync_c) |=> master_system_reset_o) else $error("sync cause missed");
    a_async_cause_asserts: assert property
        ((ce_i && |async_c) [*3] |=> master_system_reset_o)
        else $error("async cause missed");
    a_rise_needs_cause: assert property
        ($rose(master_system_reset_o) |-> $past(|{sync_c, async_c}) || $past(|async_c, 3))
        else $error("master reset rose without a cause");
    a_fall_needs_quiet: assert property
        ($fell(master_system_reset_o) |-> $past(sync_c) == 3'h0)
        else $error("master reset fell with cause active");
    a_hold_while_cause: assert property
        ((master_system_reset_o && |sync_c) |=> master_system_reset_o)
        else $error("master reset dropped early");
    a_cold_within_master: assert property
        (cold_reset_o |-> master_system_reset_o) else $error("cold reset outside master");
    a_unmapped_error: assert property
        ((acc && !mapped) |-> pslverr_o) else $error("unmapped access not refused");
    a_mapped_access_ok: assert property
        ((acc && mapped) |-> pready_o && !pslverr_o) else $error("mapped access refused");
    a_irq_drop_cause: assert property
        ($fell(irq_o) |-> $past(acc && (paddr_i == RSC_OFF_IRQ_STAT && !pwrite_i
            || paddr_i == RSC_OFF_IRQ_MASK && pwrite_i), 2))
        else $error("irq fell without clear");

    c_release: cover property ($fell(master_system_reset_o));
    c_irq_raised: cover property ($rose(irq_o));
    c_unmapped: cover property (acc && pslverr_o);
endmodule

// >>> dv/rsc_reset_combiner_tb_top.sv
/*
 * Self-checking bench of the reset source combiner over APB.
 * Assumes rsc_pkg, the design and the cause model are compiled first.
 */
`timescale 1ns/100ps

module rsc_reset_combiner_tb_top;
    import rsc_pkg::*;

    // short release hold keeps runs brief
    localparam logic [15:0] HOLD = 16'h0003;

    logic mclk_i = 1'b0;
    logic sys_rst_i, ce_i, psel_i, penable_i, pwrite_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, q, flags;
    logic [3:0] pstrb_i;
    logic pready_o, pslverr_o, irq_o, master_system_reset_o, cold_reset_o, e;
    logic [6:0] cause;
    int n_fail = 0;
    int checks = 0;
    int i;

    initial forever #4 mclk_i = ~mclk_i;

    rsc_reset_combiner #(.HOLD_DEFAULT(HOLD)) rsc_reset_combiner_inst (
        .mclk_i, .sys_rst_i, .ce_i,
        .power_on_reset_i(cause[RSC_BIT_POWER_ON]),
        .brown_out_reset_i(cause[RSC_BIT_BROWN_OUT]),
        .external_clear_pin_reset_i(cause[RSC_BIT_CLEAR_PIN]),
        .instruction_reset_i(cause[RSC_BIT_INSTRUCTION]),
        .watchdog_timeout_reset_i(cause[RSC_BIT_WATCHDOG]),
        .trap_conflict_reset_i(cause[RSC_BIT_TRAP_CONFLICT]),
        .illegal_op_uninit_reg_reset_i(cause[RSC_BIT_ILLEGAL_OP]),
        .master_system_reset_o, .cold_reset_o, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .irq_o);

    rsc_cause_model rsc_cause_model_inst (.mclk_i, .cause_o(cause));

    task automatic print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until the edge that samples pready high; the answer is taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1)
        begin
            n_fail++;
            print_verdict();
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(what, exp, q);
    endtask

    task automatic wait_rel(input int exp);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (master_system_reset_o !== 1'b0 && n < 200);
        if (n >= 200)
        begin
            n_fail++;
            print_verdict();
        end
        if (exp >= 0)
            cmp("release cycles", exp, n);
    endtask

    task automatic do_reset;
        sys_rst_i <= 1'b1;
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        cmp("master in reset", 32'h1, master_system_reset_o);
        cmp("cold in reset", 32'h1, cold_reset_o);
        wait_rel(-1);
        cmp("cold released", 32'h0, cold_reset_o);
        rd("cause after reset", RSC_OFF_CAUSE, 32'h1);
    endtask

    initial
    begin
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        pstrb_i = 4'hF;
        do_reset();
        rd("mask", RSC_OFF_IRQ_MASK, 32'h0);
        rd("hold", RSC_OFF_HOLD, {16'h0, HOLD});
        rd("count", RSC_OFF_COUNT, 32'h0);
        rd("live idle", RSC_OFF_LIVE, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        cmp("unmapped err", 32'h1, e);
        cmp("unmapped data", 32'h0, q);
        apb(1'b1, RSC_OFF_CAUSE, 32'h7F);
        rd("cause set by sw", RSC_OFF_CAUSE, 32'h7F);
        cmp("master after sw set", 32'h0, master_system_reset_o);
        apb(1'b1, RSC_OFF_CAUSE, 32'h0);
        rd("cause cleared", RSC_OFF_CAUSE, 32'h0);
        apb(1'b1, RSC_OFF_IRQ_MASK, 32'h10);
        // a frozen block must ignore the bus
        ce_i <= 1'b0;
        apb(1'b1, RSC_OFF_IRQ_MASK, 32'h7F);
        ce_i <= 1'b1;
        rd("mask frozen", RSC_OFF_IRQ_MASK, 32'h10);
        flags = 32'h0;
        // power-on last: it must wipe the flags gathered before it
        for (int k = 1; k <= 7; k++)
        begin
            i = k % 7;
            rsc_cause_model_inst.raise(i, RSC_ASYNC_CAUSES[i] ? 6 : 1);
            wait_rel(HOLD + 1 + (RSC_ASYNC_CAUSES[i] ? 2 : 0));
            cmp("irq raised", {31'h0, i == RSC_BIT_WATCHDOG}, irq_o);
            flags = (i == 0) ? 32'h1 : flags | (32'h1 << i);
            rd("cause flags", RSC_OFF_CAUSE, flags);
            rd("irq status", RSC_OFF_IRQ_STAT, 32'h1 << i);
            repeat (2) @(posedge mclk_i);
            #1;
            cmp("irq cleared", 32'h0, irq_o);
        end
        rd("count after power-on", RSC_OFF_COUNT, 32'h1);
        do_reset();
        print_verdict();
    end
endmodule

bind rsc_reset_combiner rsc_reset_combiner_properties rsc_reset_combiner_properties_inst (
    .mclk_i, .sys_rst_i, .ce_i, .power_on_reset_i, .brown_out_reset_i,
    .external_clear_pin_reset_i, .instruction_reset_i, .watchdog_timeout_reset_i,
    .trap_conflict_reset_i, .illegal_op_uninit_reg_reset_i, .master_system_reset_o,
    .cold_reset_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .irq_o);

// >>> verilog/rsc_cause_if.sv
/*
 * Carrier between the cause conditioner and the combiner core: one level
 * and one rising-edge pulse per reset cause.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps

interface rsc_cause_if #(
    parameter int N = 7
);
    logic [N-1:0] level;
    logic [N-1:0] rise;

    modport src (
        output level,
        output rise
    );

    modport dst (
        input level,
        input rise
    );
endinterface

// >>> verilog/rsc_cause_sync.sv
/*
 * Cause conditioner: double-flop synchroniser for causes from foreign
 * domains, pass-through for same-clock causes, and a rise pulse for each.
 * Assumes ce_i gates every flip-flop and sys_rst_i is synchronous.
 */
`timescale 1ns/100ps

module rsc_cause_sync #(
    parameter int N = 7,
    parameter logic [N-1:0] ASYNC_MASK = '0
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [N-1:0] raw_i,
    rsc_cause_if.src cause_o
);

    genvar g;

    generate
        for (g = 0; g < N; g++)
        begin : g_cause
            logic lvl;
            logic prev_r;

            if (ASYNC_MASK[g])
            begin : g_async
                logic meta_r;
                logic sync_r;

                // first stage feeds only the second stage
                always_ff @(posedge mclk_i)
                begin
                    if (sys_rst_i)
                    begin
                        meta_r <= 1'b0;
                        sync_r <= 1'b0;
                    end
                    else if (ce_i)
                    begin
                        meta_r <= raw_i[g];
                        sync_r <= meta_r;
                    end
                end
                assign lvl = sync_r;
            end
            else
            begin : g_sync
                assign lvl = raw_i[g];
            end

            always_ff @(posedge mclk_i)
            begin
                if (sys_rst_i)
                begin
                    prev_r <= 1'b0;
                end
                else if (ce_i)
                begin
                    prev_r <= lvl;
                end
            end

            assign cause_o.level[g] = lvl;
            assign cause_o.rise[g] = lvl & ~prev_r;
        end
    endgenerate

endmodule

// >>> verilog/rsc_pkg.sv
/*
 * Shared constants of the reset source combiner: cause numbering, register
 * offsets, field layouts, reset values and release timing.
 * Assumes a single 125 MHz system clock and a 32-bit APB register port.
 */
package rsc_pkg;

    // ------------------------------------------------------------------
    // causes and their flag positions
    // ------------------------------------------------------------------
    localparam int RSC_NUM_CAUSES = 7;
    localparam int RSC_BIT_POWER_ON = 0;
    localparam int RSC_BIT_BROWN_OUT = 1;
    localparam int RSC_BIT_CLEAR_PIN = 2;
    localparam int RSC_BIT_INSTRUCTION = 3;
    localparam int RSC_BIT_WATCHDOG = 4;
    localparam int RSC_BIT_TRAP_CONFLICT = 5;
    localparam int RSC_BIT_ILLEGAL_OP = 6;

    // power-on, brown-out, pin and watchdog arrive from other domains
    localparam logic [6:0] RSC_ASYNC_CAUSES = 7'h17;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int RSC_ADDR_W = 8;
    localparam logic [7:0] RSC_OFF_CAUSE = 8'h00;
    localparam logic [7:0] RSC_OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] RSC_OFF_IRQ_MASK = 8'h08;
    localparam logic [7:0] RSC_OFF_LIVE = 8'h0C;
    localparam logic [7:0] RSC_OFF_HOLD = 8'h10;
    localparam logic [7:0] RSC_OFF_COUNT = 8'h14;

    // live register: cause levels in [6:0], then reset outputs
    localparam int RSC_LIVE_MASTER_BIT = 8;
    localparam int RSC_LIVE_COLD_BIT = 9;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] RSC_CAUSE_RST = 7'h01;
    localparam logic [6:0] RSC_IRQ_STAT_RST = 7'h00;
    localparam logic [6:0] RSC_IRQ_MASK_RST = 7'h00;
    localparam logic [15:0] RSC_COUNT_RST = 16'h0000;

    // ------------------------------------------------------------------
    // release timing
    // ------------------------------------------------------------------
    localparam int RSC_HOLD_W = 16;
    localparam int RSC_CLK_PERIOD_PS = 8000;
    localparam int RSC_RELEASE_HOLD_NS = 64;
    localparam int RSC_RELEASE_HOLD_CYC =
        (RSC_RELEASE_HOLD_NS * 1000 + RSC_CLK_PERIOD_PS - 1) / RSC_CLK_PERIOD_PS;
    localparam logic [15:0] RSC_HOLD_RST = 16'(RSC_RELEASE_HOLD_CYC);

endpackage

// >>> verilog/rsc_reset_combiner.sv
/*
 * Reset source combiner: merges seven reset causes into the master system
 * reset, records the cause of each reset in software-visible flags and
 * raises an interrupt per cause event, all reached over APB.
 * Assumes power-on, brown-out, clear pin and watchdog inputs are asynchronous
 * to mclk_i; instruction, trap-conflict and illegal-op causes come from core
 * logic on mclk_i. This block's own state is cleared by sys_rst_i, and its flags and
 * count also by a power-on cause, never by the master reset it drives.
 */
`timescale 1ns/100ps

module rsc_reset_combiner #(
    parameter logic [rsc_pkg::RSC_HOLD_W-1:0] HOLD_DEFAULT = rsc_pkg::RSC_HOLD_RST
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // reset causes
    input wire logic power_on_reset_i,
    input wire logic brown_out_reset_i,
    input wire logic external_clear_pin_reset_i,
    input wire logic instruction_reset_i,
    input wire logic watchdog_timeout_reset_i,
    input wire logic trap_conflict_reset_i,
    input wire logic illegal_op_uninit_reg_reset_i,
    // resets out
    output logic master_system_reset_o,
    output logic cold_reset_o,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [rsc_pkg::RSC_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // interrupt
    output logic irq_o
);
    import rsc_pkg::*;

    // ------------------------------------------------------------------
    // types and helpers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RSC_ST_HELD = 2'h0,
        RSC_ST_DRAIN = 2'h1,
        RSC_ST_RUN = 2'h2
    } rsc_state_t;

    function automatic logic reg_hit(input logic [RSC_ADDR_W-1:0] addr);
        case (addr)
            RSC_OFF_CAUSE,
            RSC_OFF_IRQ_STAT,
            RSC_OFF_IRQ_MASK,
            RSC_OFF_LIVE,
            RSC_OFF_HOLD,
            RSC_OFF_COUNT: reg_hit = 1'b1;
            default: reg_hit = 1'b0;
        endcase
    endfunction

    // merge written bytes of an 16-bit-or-narrower field
    function automatic logic [15:0] strb_merge(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        logic [15:0] res;
        res = old_val;
        if (strb[0])
        begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = wdata[15:8];
        end
        strb_merge = res;
    endfunction

    // ------------------------------------------------------------------
    // cause conditioning
    // ------------------------------------------------------------------
    logic [RSC_NUM_CAUSES-1:0] raw_cause;
    logic any_cause;

    rsc_cause_if #(.N(RSC_NUM_CAUSES)) cause_bus ();

    assign raw_cause[RSC_BIT_POWER_ON] = power_on_reset_i;
    assign raw_cause[RSC_BIT_BROWN_OUT] = brown_out_reset_i;
    assign raw_cause[RSC_BIT_CLEAR_PIN] = external_clear_pin_reset_i;
    assign raw_cause[RSC_BIT_INSTRUCTION] = instruction_reset_i;
    assign raw_cause[RSC_BIT_WATCHDOG] = watchdog_timeout_reset_i;
    assign raw_cause[RSC_BIT_TRAP_CONFLICT] = trap_conflict_reset_i;
    assign raw_cause[RSC_BIT_ILLEGAL_OP] = illegal_op_uninit_reg_reset_i;

    rsc_cause_sync #(
        .N(RSC_NUM_CAUSES),
        .ASYNC_MASK(RSC_ASYNC_CAUSES)
    ) u_sync (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .raw_i(raw_cause),
        .cause_o(cause_bus)
    );

    assign any_cause = |cause_bus.level;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic hit;

    // zero-wait slave: every access completes in its first access cycle
    assign pready_o = 1'b1;
    assign hit = reg_hit(paddr_i);
    assign acc = psel_i & penable_i & ce_i;
    assign wr_acc = acc & pwrite_i & hit;
    assign rd_acc = acc & ~pwrite_i & hit;
    assign pslverr_o = psel_i & penable_i & ~hit;

    // ------------------------------------------------------------------
    // master reset sequencing
    // ------------------------------------------------------------------
    rsc_state_t state_r;
    rsc_state_t state_nxt;
    logic [RSC_HOLD_W-1:0] hold_cfg_r;
    logic [RSC_HOLD_W-1:0] hold_cnt_r;
    logic master_rst_r;
    logic cold_rst_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            RSC_ST_HELD:
            begin
                // stay while any cause is still active
                if (!any_cause)
                begin
                    state_nxt = (hold_cfg_r == '0) ? RSC_ST_RUN : RSC_ST_DRAIN;
                end
            end
            RSC_ST_DRAIN:
            begin
                if (any_cause)
                begin
                    state_nxt = RSC_ST_HELD;
                end
                else if (hold_cnt_r <= 16'h0001)
                begin
                    state_nxt = RSC_ST_RUN;
                end
            end
            RSC_ST_RUN:
            begin
                if (any_cause)
                begin
                    state_nxt = RSC_ST_HELD;
                end
            end
            default:
            begin
                state_nxt = RSC_ST_HELD;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= RSC_ST_HELD;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
        end
    end

    // hold counter restarts on every entry to the drain phase
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            hold_cnt_r <= '0;
        end
        else if (ce_i)
        begin
            if (state_r != RSC_ST_DRAIN)
            begin
                hold_cnt_r <= hold_cfg_r;
            end
            else if (hold_cnt_r != '0)
            begin
                hold_cnt_r <= hold_cnt_r - 16'h0001;
            end
        end
    end

    // registered output so release lands on a clock edge
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            master_rst_r <= 1'b1;
        end
        else if (ce_i)
        begin
            master_rst_r <= (state_nxt != RSC_ST_RUN);
        end
    end

    // cold reset marks a power-on reset: targets with no warm reset
    // value reinitialise only on this one
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            cold_rst_r <= 1'b1;
        end
        else if (ce_i)
        begin
            if (cause_bus.level[RSC_BIT_POWER_ON])
            begin
                cold_rst_r <= 1'b1;
            end
            else if (state_nxt == RSC_ST_RUN)
            begin
                cold_rst_r <= 1'b0;
            end
        end
    end

    assign master_system_reset_o = master_rst_r;
    assign cold_reset_o = cold_rst_r;

    // ------------------------------------------------------------------
    // reset cause flags
    // ------------------------------------------------------------------
    logic [RSC_NUM_CAUSES-1:0] cause_r;
    logic [RSC_NUM_CAUSES-1:0] cause_nxt;

    always_comb
    begin
        cause_nxt = cause_r;
        if (wr_acc && paddr_i == RSC_OFF_CAUSE && pstrb_i[0])
        begin
            // plain store; no path from here to the reset logic
            cause_nxt = pwdata_i[RSC_NUM_CAUSES-1:0];
        end
        // a cause edge beats a same-cycle software clear
        cause_nxt = cause_nxt | cause_bus.rise;
        if (cause_bus.rise[RSC_BIT_POWER_ON])
        begin
            cause_nxt = RSC_CAUSE_RST;
        end
    end

    // untouched by the master reset, so flags survive warm resets
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            cause_r <= RSC_CAUSE_RST;
        end
        else if (ce_i)
        begin
            cause_r <= cause_nxt;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    logic [RSC_NUM_CAUSES-1:0] irq_stat_r;
    logic [RSC_NUM_CAUSES-1:0] irq_mask_r;
    logic irq_r;

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            irq_stat_r <= RSC_IRQ_STAT_RST;
        end
        else if (ce_i)
        begin
            if (rd_acc && paddr_i == RSC_OFF_IRQ_STAT)
            begin
                irq_stat_r <= cause_bus.rise;
            end
            else
            begin
                irq_stat_r <= irq_stat_r | cause_bus.rise;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            irq_mask_r <= RSC_IRQ_MASK_RST;
        end
        else if (ce_i && wr_acc && paddr_i == RSC_OFF_IRQ_MASK && pstrb_i[0])
        begin
            irq_mask_r <= pwdata_i[RSC_NUM_CAUSES-1:0];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            irq_r <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign irq_o = irq_r;

    // ------------------------------------------------------------------
    // release hold and reset counter
    // ------------------------------------------------------------------
    logic [15:0] reset_cnt_r;

    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            hold_cfg_r <= HOLD_DEFAULT;
        end
        else if (ce_i && wr_acc && paddr_i == RSC_OFF_HOLD)
        begin
            hold_cfg_r <= strb_merge(hold_cfg_r, pwdata_i, pstrb_i);
        end
    end

    // counts entries into reset; a power-on restarts the count at one
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            reset_cnt_r <= RSC_COUNT_RST;
        end
        else if (ce_i)
        begin
            if (cause_bus.rise[RSC_BIT_POWER_ON])
            begin
                reset_cnt_r <= 16'h0001;
            end
            else if (wr_acc && paddr_i == RSC_OFF_COUNT)
            begin
                reset_cnt_r <= strb_merge(reset_cnt_r, pwdata_i, pstrb_i);
            end
            else if (state_r == RSC_ST_RUN && any_cause && reset_cnt_r != 16'hFFFF)
            begin
                reset_cnt_r <= reset_cnt_r + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [31:0] rdata;
    logic [31:0] prdata_r;

    always_comb
    begin
        rdata = 32'h0000_0000;
        case (paddr_i)
            RSC_OFF_CAUSE:
            begin
                rdata[RSC_NUM_CAUSES-1:0] = cause_r;
            end
            RSC_OFF_IRQ_STAT:
            begin
                rdata[RSC_NUM_CAUSES-1:0] = irq_stat_r;
            end
            RSC_OFF_IRQ_MASK:
            begin
                rdata[RSC_NUM_CAUSES-1:0] = irq_mask_r;
            end
            RSC_OFF_LIVE:
            begin
                rdata[RSC_NUM_CAUSES-1:0] = cause_bus.level;
                rdata[RSC_LIVE_MASTER_BIT] = master_rst_r;
                rdata[RSC_LIVE_COLD_BIT] = cold_rst_r;
            end
            RSC_OFF_HOLD:
            begin
                rdata[RSC_HOLD_W-1:0] = hold_cfg_r;
            end
            RSC_OFF_COUNT:
            begin
                rdata[15:0] = reset_cnt_r;
            end
            default:
            begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // data captured in setup so it is a flop output during the access cycle
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else if (ce_i && psel_i && !penable_i && !pwrite_i)
        begin
            prdata_r <= rdata;
        end
    end

    assign prdata_o = prdata_r;

endmodule
